//--- elr_pkg.sv
package elr_pkg;
	// =====================================================
	// sizes
	localparam int EVENT_COUNT = 63;
	localparam int CODE_W = 8;
	// codes are sparse: the 63 sources sit at their select codes in this space
	localparam int CODE_SLOTS = (1 << CODE_W) - 1;
	localparam int DEST_COUNT = 11;
	localparam int PORT_W = 8;
	localparam int LINK_PORTS = 4;
	// =====================================================
	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_IRQ2_SEL = 8'h04;
	localparam logic [7:0] ADDR_OUTG2_SEL = 8'h08;
	localparam logic [7:0] ADDR_ING2_SEL = 8'h0c;
	localparam logic [7:0] ADDR_SP2_SEL = 8'h10;
	localparam logic [7:0] ADDR_SP3_SEL = 8'h14;
	localparam logic [7:0] ADDR_SLOW_SEL = 8'h18;
	localparam logic [7:0] ADDR_ODIS_SEL = 8'h1c;
	localparam logic [7:0] ADDR_GROUP1_SEL = 8'h20;
	localparam logic [7:0] ADDR_GROUP2_SEL = 8'h24;
	localparam logic [7:0] ADDR_GROUP2_CTL = 8'h28;
	localparam logic [7:0] ADDR_GROUP2_BUF = 8'h2c;
	localparam logic [7:0] ADDR_LINK0 = 8'h30;
	localparam logic [7:0] ADDR_STATUS = 8'h40;
	// =====================================================
	// fields and values
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int PORTNUM_LO = 3;
	localparam int PORTNUM_HI = 4;
	localparam int BITSEL_LO = 0;
	localparam int BITSEL_HI = 2;
	localparam logic [1:0] PORTNUM_OFF = 2'b00;
	localparam logic [1:0] PORTNUM_B = 2'b01;
	localparam logic [1:0] PORTNUM_E = 2'b10;
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_RTC_PERIOD = 8'h2e;
	localparam logic [7:0] CODE_WATCHDOG = 8'h31;
	localparam logic [7:0] CODE_SPI_ERROR = 8'h52;
	localparam logic [7:0] CODE_SPI_IDLE = 8'h53;
	localparam logic [7:0] CODE_SPI_RX_FULL = 8'h54;
	localparam logic [7:0] CODE_SPI_TX_EMPTY = 8'h55;
	localparam logic [7:0] CODE_SPI_TX_END = 8'h56;
	localparam logic [7:0] CODE_OSC_STOP = 8'h62;
	localparam logic [7:0] CODE_IN_GROUP2_EDGE = 8'h64;
	localparam logic [7:0] CODE_SP2_EDGE = 8'h67;
	localparam logic [7:0] CODE_SP3_EDGE = 8'h68;
	localparam logic [7:0] RESET_SEL = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// destination indexes
	localparam int DST_IRQ2 = 0;
	localparam int DST_OUTG2 = 1;
	localparam int DST_ING2 = 2;
	localparam int DST_SP2 = 3;
	localparam int DST_SP3 = 4;
	localparam int DST_SLOW = 5;
	localparam int DST_ODIS = 6;
	localparam int DST_LINK0 = 7;
endpackage : elr_pkg

//--- elr_event_mux.sv
`timescale 1ns/10ps
// one destination: pick a source by code, emit one pulse per rising event level
module elr_event_mux #(
	parameter int EVENTS = 255
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic runEnable,
	input wire logic [7:0] selCode,
	input wire logic [EVENTS:1] srcEvent,
	output logic pulseOut
);
	typedef struct packed {
		logic prevLevel;
		logic pulse;
	} elr_mux_s;
	elr_mux_s st_reg;
	elr_mux_s st_next;
	logic level;

	// =====================================================
	// selection
	always_comb begin
		level = 1'b0;
		// code zero and codes above the source count route nothing
		if (selCode != 8'h00 && int'(selCode) <= EVENTS) begin
			level = srcEvent[selCode];
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.prevLevel = runEnable & level;
		st_next.pulse = runEnable & level & ~st_reg.prevLevel;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pulseOut = st_reg.pulse;

	property p_single;
		@(posedge core_clk) disable iff (!resetn) pulseOut |=> !pulseOut;
	endproperty
	a_single: assert property (p_single) else $error("pulse longer than one cycle");
endmodule : elr_event_mux

//--- elr_event_link_router.sv
`timescale 1ns/10ps
// What this block does
// - routes any of 63 event inputs straight to destinations, no processor needed
// - port linking exists only for port B and port E
// - single-port mode links exactly one selected port bit
// - port-group mode links software-chosen bits of one 8-bit port
// - software can stop the module to save power
// - port number field bits 4:3: 00 off, 01 port B, 10 port E
// - four single-port link setting registers, index 0 to 3
// - code 2Eh is the real-time clock periodic event
// - code 31h is the independent watchdog underflow or refresh error
// - codes 52h..56h are serial channel 0 error, idle, rx full, tx empty, end
// - code 62h is oscillator stop detection
// - code 64h is the second input port group edge event
// - codes 67h and 68h are single input port 2 and 3 edges
// - irq2 select register routes its event to interrupt input 2
// - two selects trigger second output group and second input group
// - two selects trigger single port 2 and single port 3
// - one select triggers clock switch to low-speed oscillator
// - one select triggers the output disable unit
// - an event on interrupt input raises its event-link interrupt request
module elr_event_link_router
	import elr_pkg::*;
#(
	parameter int EVENTS = elr_pkg::CODE_SLOTS
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [EVENTS:1] srcEvent,
	input wire logic [7:0] portBIn,
	input wire logic [7:0] portEIn,
	output logic irq2EventReq,
	output logic outGroup2Trigger,
	output logic inGroup2Trigger,
	output logic singlePort2Trigger,
	output logic singlePort3Trigger,
	output logic slowOscSwitchTrigger,
	output logic outputDisableTrigger,
	output logic [3:0] linkPortTrigger,
	output logic [7:0] portBLinkMask,
	output logic [7:0] portELinkMask,
	output logic [7:0] group2BufferData
);
	typedef struct packed {
		logic enable;
		logic stop;
		logic [6:0][7:0] sel;
		logic [7:0] group1Sel;
		logic [7:0] group2Sel;
		logic [7:0] group2Ctl;
		logic [7:0] group2Buf;
		logic [3:0][7:0] linkSet;
		logic [7:0] bMask;
		logic [7:0] eMask;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} elr_state_s;
	elr_state_s st_reg;
	elr_state_s st_next;
	logic running;
	logic [DEST_COUNT-1:0] destPulse;
	logic [DEST_COUNT-1:0][7:0] destCode;
	logic doWrite;
	logic [7:0] wa;
	logic [31:0] wd;

	// =====================================================
	// port number decode, used for masks and for link pin triggers
	function automatic logic [7:0] link_bit_mask(input logic [7:0] setting, input logic [1:0] port);
		logic [7:0] m;
		m = 8'h00;
		// only B and E may be linked; 11 never selects a port
		if (setting[PORTNUM_HI:PORTNUM_LO] == port && port != PORTNUM_OFF) begin
			m[setting[BITSEL_HI:BITSEL_LO]] = 1'b1; // one bit per setting
		end
		return m;
	endfunction : link_bit_mask

	function automatic logic reg_hit(input logic [7:0] a);
		return (a <= ADDR_LINK0 + 8'h0c && a[1:0] == 2'b00) || a == ADDR_STATUS;
	endfunction : reg_hit

	// stop holds all routing idle, the clock tree gate is outside
	assign running = st_reg.enable & ~st_reg.stop;

	// =====================================================
	// destinations
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			destCode[i] = st_reg.sel[i];
		end
		for (int i = 0; i < LINK_PORTS; i++) begin
			// link slots fire from pin levels, not from a code
			destCode[DST_LINK0+i] = CODE_NONE;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : gen_dest
			// select code is the source slot number
			// any source reaches any destination directly
			elr_event_mux #(.EVENTS(EVENTS)) u_mux (
				.core_clk(core_clk),
				.resetn(resetn),
				.runEnable(running),
				.selCode(destCode[g]),
				.srcEvent(srcEvent),
				.pulseOut(destPulse[g])
			);
		end
		for (g = 0; g < LINK_PORTS; g++) begin : gen_link
			// single-port setting fires when its selected pin is high and linked
			assign destPulse[DST_LINK0+g] = running &
				(|(link_bit_mask(st_reg.linkSet[g], PORTNUM_B) & portBIn) |
				 |(link_bit_mask(st_reg.linkSet[g], PORTNUM_E) & portEIn));
		end
	endgenerate

	assign irq2EventReq = destPulse[DST_IRQ2];
	assign outGroup2Trigger = destPulse[DST_OUTG2];
	assign inGroup2Trigger = destPulse[DST_ING2];
	assign singlePort2Trigger = destPulse[DST_SP2];
	assign singlePort3Trigger = destPulse[DST_SP3];
	assign slowOscSwitchTrigger = destPulse[DST_SLOW];
	assign outputDisableTrigger = destPulse[DST_ODIS];
	assign linkPortTrigger = destPulse[DST_LINK0+LINK_PORTS-1:DST_LINK0];
	assign portBLinkMask = st_reg.bMask;
	assign portELinkMask = st_reg.eMask;
	assign group2BufferData = st_reg.group2Buf;

	// =====================================================
	// bus slave
	// ready drops while an item or a response waits, so no second write overtakes it
	assign s_axi_awready = ~st_reg.awHeld & ~st_reg.bValid;
	assign s_axi_wready = ~st_reg.wHeld & ~st_reg.bValid;
	assign s_axi_arready = ~st_reg.rValid;
	assign s_axi_bvalid = st_reg.bValid;
	assign s_axi_bresp = st_reg.bResp;
	assign s_axi_rvalid = st_reg.rValid;
	assign s_axi_rdata = st_reg.rData;
	assign s_axi_rresp = st_reg.rResp;
	assign doWrite = st_reg.awHeld & st_reg.wHeld & ~st_reg.bValid;
	assign wa = st_reg.awAddr;
	assign wd = st_reg.wData;

	always_comb begin
		logic [7:0] lb;
		logic [7:0] le;
		logic [31:0] rd;
		lb = 8'h00;
		le = 8'h00;
		rd = 32'h0000_0000;
		st_next = st_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.wHeld = 1'b1;
			st_next.wData = s_axi_wdata;
			st_next.wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			st_next.bValid = 1'b1;
			st_next.bResp = reg_hit(wa) && wa != ADDR_STATUS ? RESP_OKAY : RESP_SLVERR;
			if (st_reg.wStrb[0]) begin
				case (wa)
					ADDR_CONTROL: begin
						st_next.enable = wd[CTRL_ENABLE_BIT];
						st_next.stop = wd[CTRL_STOP_BIT];
					end
					ADDR_GROUP1_SEL: st_next.group1Sel = wd[7:0];
					ADDR_GROUP2_SEL: st_next.group2Sel = wd[7:0];
					ADDR_GROUP2_CTL: st_next.group2Ctl = wd[7:0];
					ADDR_GROUP2_BUF: st_next.group2Buf = wd[7:0];
					default: begin
						if (wa >= ADDR_IRQ2_SEL && wa <= ADDR_ODIS_SEL) begin
							st_next.sel[3'(wa[4:2] - 3'd1)] = wd[7:0];
						end else if (wa >= ADDR_LINK0 && wa <= ADDR_LINK0 + 8'h0c) begin
							// setting 11 is illegal, dropped
							if (wd[PORTNUM_HI:PORTNUM_LO] != 2'b11) begin
								st_next.linkSet[wa[3:2]] = wd[7:0];
							end
						end
					end
				endcase
			end
		end
		if (st_reg.bValid && s_axi_bready) begin
			st_next.bValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rValid = 1'b1;
			st_next.rResp = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_CONTROL: rd = {30'h0, st_reg.stop, st_reg.enable};
				ADDR_GROUP1_SEL: rd = {24'h0, st_reg.group1Sel};
				ADDR_GROUP2_SEL: rd = {24'h0, st_reg.group2Sel};
				ADDR_GROUP2_CTL: rd = {24'h0, st_reg.group2Ctl};
				ADDR_GROUP2_BUF: rd = {24'h0, st_reg.group2Buf};
				ADDR_STATUS: rd = {21'h0, destPulse};
				default: begin
					if (s_axi_araddr >= ADDR_IRQ2_SEL && s_axi_araddr <= ADDR_ODIS_SEL) begin
						rd = {24'h0, st_reg.sel[3'(s_axi_araddr[4:2] - 3'd1)]};
					end else if (s_axi_araddr >= ADDR_LINK0 && s_axi_araddr <= ADDR_LINK0 + 8'h0c) begin
						rd = {24'h0, st_reg.linkSet[s_axi_araddr[3:2]]};
					end
				end
			endcase
			st_next.rData = rd;
		end else if (st_reg.rValid && s_axi_rready) begin
			st_next.rValid = 1'b0;
		end
		// group masks: port B on first group, port E on second
		for (int i = 0; i < LINK_PORTS; i++) begin
			lb = lb | link_bit_mask(st_next.linkSet[i], PORTNUM_B);
			le = le | link_bit_mask(st_next.linkSet[i], PORTNUM_E);
		end
		// masks follow st_next so they move on the same edge as the setting
		st_next.bMask = st_next.stop ? 8'h00 : (lb | st_next.group1Sel);
		st_next.eMask = st_next.stop ? 8'h00 : (le | st_next.group2Sel);
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// =====================================================
	// checks
	// a routed event is high for one cycle and then low again
	sequence s_irq2_pulse;
		irq2EventReq ##1 !irq2EventReq;
	endsequence

	sequence s_sp2_pulse;
		singlePort2Trigger ##1 !singlePort2Trigger;
	endsequence

	property p_stop_quiet;
		@(posedge core_clk) disable iff (!resetn)
			st_reg.stop [*2] |-> !irq2EventReq && !outputDisableTrigger;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("event during stop");

	property p_irq_path;
		@(posedge core_clk) disable iff (!resetn)
			running && st_reg.sel[DST_IRQ2] == CODE_WATCHDOG && $rose(srcEvent[8'h31])
			&& $stable(st_reg.sel[DST_IRQ2]) |=> s_irq2_pulse;
	endproperty
	a_irq_path: assert property (p_irq_path) else $error("irq2 not raised");

	property p_zero_code;
		@(posedge core_clk) disable iff (!resetn)
			st_reg.sel[DST_SLOW] == CODE_NONE && $past(st_reg.sel[DST_SLOW]) == CODE_NONE
			|-> !slowOscSwitchTrigger;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("code zero routed");

	property p_no_port_c;
		@(posedge core_clk) disable iff (!resetn)
			st_reg.linkSet[0][PORTNUM_HI:PORTNUM_LO] != 2'b11;
	endproperty
	a_no_port_c: assert property (p_no_port_c) else $error("illegal port number stored");

	property p_bresp_follow;
		@(posedge core_clk) disable iff (!resetn) doWrite |=> s_axi_bvalid;
	endproperty
	a_bresp_follow: assert property (p_bresp_follow) else $error("no write response");

	property p_rtc;
		@(posedge core_clk) disable iff (!resetn)
			running && st_reg.sel[DST_SP2] == CODE_RTC_PERIOD && $rose(srcEvent[8'h2e])
			&& $stable(st_reg.sel[DST_SP2]) |=> s_sp2_pulse;
	endproperty
	a_rtc: assert property (p_rtc) else $error("rtc event not a pulse");

	property p_mask_stop;
		@(posedge core_clk) disable iff (!resetn) st_reg.stop |-> portELinkMask == 8'h00;
	endproperty
	a_mask_stop: assert property (p_mask_stop) else $error("mask live in stop");

	property p_read_lat;
		@(posedge core_clk) disable iff (!resetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("no read data");

	property p_zero_irq;
		@(posedge core_clk) disable iff (!resetn)
			st_reg.sel[DST_IRQ2] == CODE_NONE && $past(st_reg.sel[DST_IRQ2]) == CODE_NONE
			|-> !irq2EventReq;
	endproperty
	a_zero_irq: assert property (p_zero_irq) else $error("code zero routed to irq2");

	property p_link_stop;
		@(posedge core_clk) disable iff (!resetn) !running |-> linkPortTrigger == 4'h0;
	endproperty
	a_link_stop: assert property (p_link_stop) else $error("link pin fired while idle");

	for (g = 0; g < LINK_PORTS; g++) begin : gen_link_chk
		property p_link_legal;
			@(posedge core_clk) disable iff (!resetn)
				st_reg.linkSet[g][PORTNUM_HI:PORTNUM_LO] != 2'b11;
		endproperty
		a_link_legal: assert property (p_link_legal) else $error("illegal port stored");
	end

	property p_mask_b_stop;
		@(posedge core_clk) disable iff (!resetn) st_reg.stop |-> portBLinkMask == 8'h00;
	endproperty
	a_mask_b_stop: assert property (p_mask_b_stop) else $error("port b mask live in stop");
endmodule : elr_event_link_router

//--- elr_event_source.sv
`timescale 1ns/10ps
// =====================================================
// peripheral event sources seen by the router
module elr_event_source
	import elr_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic fireReq,
	input wire logic [7:0] fireCode,
	output logic [elr_pkg::CODE_SLOTS:1] srcEvent
);
	logic [2:0] holdCnt;
	logic [7:0] liveCode;
	// level held several cycles: a router firing per level, not per rise, shows it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			holdCnt <= 3'h0;
			liveCode <= 8'h00;
		end else if (fireReq) begin
			holdCnt <= 3'h4;
			liveCode <= fireCode;
		end else if (holdCnt != 3'h0) begin
			holdCnt <= holdCnt - 3'h1;
		end
	end
	always_comb begin
		srcEvent = '0;
		// code zero drives nothing
		if (holdCnt != 3'h0 && liveCode != 8'h00) begin
			srcEvent[liveCode] = 1'b1;
		end
	end
endmodule : elr_event_source

//--- elr_event_link_router_test.sv
`timescale 1ns/10ps
module elr_event_link_router_test;
	import elr_pkg::*;
	logic core_clk = 0, resetn = 0;
	logic [7:0] awaddr = 0, araddr = 0, fireCode = 0, portBIn = 0, portEIn = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, fireReq = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [6:0] dst;
	logic [3:0] linkTrig;
	logic [7:0] bMask, eMask, g2Buf;
	logic [CODE_SLOTS:1] srcEvent;
	int nErrors = 0, samplesChecked = 0;
	logic [7:0] codes [11] = '{CODE_RTC_PERIOD, CODE_WATCHDOG, CODE_SPI_ERROR, CODE_SPI_IDLE,
		CODE_SPI_RX_FULL, CODE_SPI_TX_EMPTY, CODE_SPI_TX_END, CODE_OSC_STOP,
		CODE_IN_GROUP2_EDGE, CODE_SP2_EDGE, CODE_SP3_EDGE};
	always #50 core_clk = ~core_clk;
	elr_event_source src_u (.core_clk(core_clk), .resetn(resetn), .fireReq(fireReq),
		.fireCode(fireCode), .srcEvent(srcEvent));
	elr_event_link_router dut_u (.core_clk(core_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.srcEvent(srcEvent), .portBIn(portBIn), .portEIn(portEIn), .irq2EventReq(dst[0]),
		.outGroup2Trigger(dst[1]), .inGroup2Trigger(dst[2]), .singlePort2Trigger(dst[3]),
		.singlePort3Trigger(dst[4]), .slowOscSwitchTrigger(dst[5]),
		.outputDisableTrigger(dst[6]), .linkPortTrigger(linkTrig), .portBLinkMask(bMask),
		.portELinkMask(eMask), .group2BufferData(g2Buf));
	// =====================================================
	// checking and bus tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samplesChecked++;
		if (s !== e) begin
			$display("BAD %s exp %h seen %h", n, e, s);
			nErrors++;
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// valid held until the rising edge that sees ready; answer taken at the first edge that sees bvalid or rvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit bDone = 0;
		int n = 0;
		logic [1:0] r;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bDone && n < 50) begin
			@(posedge core_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bDone = 1'b1;
				r = bresp;
			end
		end
		bready <= 1'b0;
		if (!bDone) nErrors++;
		chk("bresp", 32'(r), 32'(RESP_OKAY));
	endtask : wr
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit rDone = 0;
		int n = 0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rDone && n < 50) begin
			@(posedge core_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rDone = 1'b1;
				d = rdata;
				r = rresp;
			end
		end
		rready <= 1'b0;
		if (!rDone) nErrors++;
	endtask : rdr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdr(a, d, r);
		chk("rdata", d, e);
		chk("rresp", 32'(r), 32'(RESP_OKAY));
	endtask : rd
	task automatic fire(input logic [7:0] c, input logic [6:0] em);
		logic [6:0] seen = 0;
		int cnt = 0;
		@(posedge core_clk);
		fireCode <= c;
		fireReq <= 1'b1;
		@(posedge core_clk);
		fireReq <= 1'b0;
		repeat (8) begin
			@(negedge core_clk);
			seen |= dst;
			cnt += $countones(dst);
		end
		chk("pulseMask", 32'(seen), 32'(em));
		chk("pulseCount", cnt, (em != 0) ? 1 : 0);
	endtask : fire
	// =====================================================
	// tests
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(ADDR_IRQ2_SEL + 8'(4 * i), 32'(RESET_SEL));
		rdr(8'h44, d, r);
		chk("unmappedResp", 32'(r), 32'(RESP_SLVERR));
		$display("test resetAndMap done");
		wr(ADDR_CONTROL, 32'h1);
		for (int k = 0; k < 11; k++) begin
			wr(ADDR_IRQ2_SEL + 8'(4 * (k % 7)), 32'(codes[k]));
			rd(ADDR_IRQ2_SEL + 8'(4 * (k % 7)), 32'(codes[k]));
			fire(codes[k], 7'(1 << (k % 7)));
		end
		wr(ADDR_IRQ2_SEL, 32'(CODE_NONE));
		fire(CODE_OSC_STOP, 7'h00);
		fire(8'h01, 7'h00);
		wr(ADDR_IRQ2_SEL, 32'(CODE_WATCHDOG));
		wr(ADDR_SP2_SEL, 32'(CODE_RTC_PERIOD));
		fire(CODE_WATCHDOG, 7'h01);
		fire(CODE_RTC_PERIOD, 7'h08);
		wr(ADDR_CONTROL, 32'h3);
		fire(CODE_IN_GROUP2_EDGE, 7'h00);
		wr(ADDR_CONTROL, 32'h1);
		fire(CODE_IN_GROUP2_EDGE, 7'h02);
		$display("test routing done");
		@(posedge core_clk);
		portBIn <= 8'h08;
		portEIn <= 8'h20;
		wr(ADDR_LINK0, 32'h0b);
		wr(ADDR_LINK0 + 8'h04, 32'h18);
		rd(ADDR_LINK0 + 8'h04, 32'h0);
		wr(ADDR_LINK0 + 8'h08, 32'h15);
		wr(ADDR_GROUP1_SEL, 32'ha0);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("linkTrig", 32'(linkTrig), 32'h5);
		chk("portBMask", 32'(bMask), 32'ha8);
		chk("portEMask", 32'(eMask), 32'h20);
		@(posedge core_clk);
		portBIn <= 8'h00;
		@(negedge core_clk);
		chk("linkTrigLow", 32'(linkTrig), 32'h4);
		wr(ADDR_GROUP2_BUF, 32'h5a);
		chk("group2Buf", 32'(g2Buf), 32'h5a);
		rd(ADDR_GROUP2_BUF, 32'h5a);
		wr(ADDR_CONTROL, 32'h3);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("stopMask", 32'(bMask), 32'h0);
		chk("stopTrig", 32'(linkTrig), 32'h0);
		$display("test portLink done");
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		nErrors++;
		print_verdict();
	end
endmodule : elr_event_link_router_test
